// *** core/trc_regs.sv ***
// Purpose: top control, configuration and event registers of the multiphase regulator
// Assumes: register port driven by the serial front end, one access per strobe
// Notes:   config defaults come from the one-time-programmable word at start-up
// Notes on behaviour
// R1 - soft reset write restores defaults, reloads, resets serial
// R2 - soft reset bit clears itself
// R3 - double bit selects 1 ms or 2 ms steps
// R4 - clock input pulldown follows its bit
// R5 - bits 4,2,1 drive enable input pulldowns
// R6 - threshold bit picks 125 or 137 degrees
// R7 - bits 6,5 show pending phase events
// R8 - summary clears with phase register; writes ignored
// R9 - invalid external clock latches a flag
// R10 - thermal shutdown latches, disables and blocks regulators
// R11 - thermal warning latches; live status separate
// R12 - input overvoltage latches; live status separate
// R13 - new load result latches done flag
// R14 - flags clear only by writing one
// R15 - reset flag latches after power, undervoltage, soft reset
// R16 - reset disables regulators, restores defaults, restarts
// R17 - phase registers hold sticky good, short, limit
// R18 - flags stay set; writing zero changes nothing
// R19 - set in the clearing cycle wins
`timescale 1ns/100ps
`include "trc_params.svh"
module trc_regs (
    input  wire logic                core_clk_in,
    input  wire logic                rst_in,
    input  wire logic [7:0]          reg_addr_in,
    input  wire logic                reg_wr_in,
    input  wire logic                reg_rd_in,
    input  wire trc_pkg::trc_byte_type reg_wdata_in,
    output      trc_pkg::trc_byte_type reg_rdata_out,
    input  wire logic                power_on_reset_n_in,
    input  wire logic                analog_supply_uv_in,
    input  wire trc_pkg::trc_byte_type otp_config_in,
    input  wire logic                otp_done_in,
    input  wire logic                ext_clk_invalid_in,
    input  wire logic                thermal_shutdown_live_in,
    input  wire logic                thermal_warn_125_in,
    input  wire logic                thermal_warn_137_in,
    input  wire logic                overvoltage_live_in,
    input  wire logic                load_result_ready_in,
    input  wire logic [3:0]          phase_pg_in,
    input  wire logic [3:0]          phase_sc_in,
    input  wire logic [3:0]          phase_ilim_in,
    output      logic                otp_load_out,
    output      logic                serial_if_reset_out,
    output      logic                regulator_enable_ok_out,
    output      logic                delay_double_out,
    output      logic [1:0]          delay_step_ms_out,
    output      logic                ext_clk_pulldown_en_out,
    output      logic                enable_in1_pulldown_en_out,
    output      logic                enable_in2_pulldown_en_out,
    output      logic                enable_in3_pulldown_en_out,
    output      logic                thermal_warn_threshold_sel_out,
    output      logic                thermal_warn_flag_out
);
    import trc_pkg::*;

    trc_seq_state_type     state_reg;
    trc_seq_state_type     state_next;
    logic [7:0]            hold_cnt_reg;
    logic                  soft_reset_cmd_reg;
    logic [6:0]            srst_rsvd_reg;
    trc_byte_type          cfg_reg;
    logic                  top_rsvd_reg;
    logic [6:0]            rstev_rsvd_reg;
    trc_byte_type          rd_mux;
    logic                  run;
    logic                  power_ok;
    logic                  wr_ok;
    logic                  srst_wr;
    logic                  warn_hit;
    logic                  phase01_pending;
    logic                  phase23_pending;
    wire [`TRC_NFLAGS-1:0] set_vec;
    wire [`TRC_NFLAGS-1:0] clr_vec;

    trc_flag_if fl ();

    trc_flag_bank u_flags (
        .core_clk_in (core_clk_in),
        .rst_in      (rst_in),
        .fl          (fl.bank)
    );

    assign run      = (state_reg == TRC_ST_RUN);
    assign power_ok = power_on_reset_n_in && !analog_supply_uv_in;
    // serial front end is held in reset only in hold and leaves it during the load, but only run-time writes count
    assign wr_ok    = reg_wr_in && run;
    assign srst_wr  = wr_ok && (reg_addr_in == `TRC_ADDR_SRST) && reg_wdata_in[`TRC_SRST_BIT];

    // reset sequencer
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            TRC_ST_HOLD: begin
                if (power_ok && (hold_cnt_reg == 8'(`TRC_SRST_HOLD_CYC - 1))) begin
                    state_next = TRC_ST_OTP;
                end
            end
            TRC_ST_OTP: begin
                if (!power_ok) begin
                    state_next = TRC_ST_HOLD;                // [R16]
                end else if (otp_done_in) begin
                    state_next = TRC_ST_RUN;
                end
            end
            TRC_ST_RUN: begin
                if (!power_ok || srst_wr) begin
                    state_next = TRC_ST_HOLD;                // [R1] [R16]
                end
            end
            default: begin
                state_next = TRC_ST_HOLD;
            end
        endcase
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg <= TRC_ST_HOLD;
        end else begin
            state_reg <= state_next;
        end
    end

    // hold time restarts while power is bad so a brownout gets a full reset
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            hold_cnt_reg <= 8'h00;
        end else if (state_reg != TRC_ST_HOLD || !power_ok) begin
            hold_cnt_reg <= 8'h00;
        end else if (hold_cnt_reg != 8'(`TRC_SRST_HOLD_CYC - 1)) begin
            hold_cnt_reg <= hold_cnt_reg + 8'h01;
        end
    end

    // soft reset register
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            soft_reset_cmd_reg <= 1'b0;
            srst_rsvd_reg      <= 7'(`TRC_SRST_RESET >> 1);
        end else if (state_reg == TRC_ST_HOLD) begin
            soft_reset_cmd_reg <= 1'b0;                      // [R2]
            srst_rsvd_reg      <= 7'(`TRC_SRST_RESET >> 1);
        end else if (wr_ok && reg_addr_in == `TRC_ADDR_SRST) begin
            soft_reset_cmd_reg <= reg_wdata_in[`TRC_SRST_BIT];
            srst_rsvd_reg      <= reg_wdata_in[7:1];
        end
    end

    // configuration, reloaded from the programmed word on every restart
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cfg_reg <= `TRC_CFG_RESET;
        end else if (state_reg == TRC_ST_HOLD) begin
            cfg_reg <= `TRC_CFG_RESET;                       // [R16]
        end else if (state_reg == TRC_ST_OTP && otp_done_in) begin
            cfg_reg <= otp_config_in & ~`TRC_CFG_RSVD_MASK;  // [R1]
        end else if (wr_ok && reg_addr_in == `TRC_ADDR_CFG) begin
            cfg_reg <= reg_wdata_in;
        end
    end

    // reserved read/write bits of the event registers
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            top_rsvd_reg   <= 1'b0;
            rstev_rsvd_reg <= 7'(`TRC_EVENT_RESET >> 1);
        end else if (state_reg == TRC_ST_HOLD) begin
            top_rsvd_reg   <= 1'b0;
            rstev_rsvd_reg <= 7'(`TRC_EVENT_RESET >> 1);
        end else if (wr_ok && reg_addr_in == `TRC_ADDR_TOP) begin
            top_rsvd_reg   <= reg_wdata_in[7];
        end else if (wr_ok && reg_addr_in == `TRC_ADDR_RSTEV) begin
            rstev_rsvd_reg <= reg_wdata_in[7:1];
        end
    end

    // event sources; a level held high keeps re-setting its flag
    assign warn_hit = cfg_reg[`TRC_CFG_WARNSEL_BIT] ? thermal_warn_137_in : thermal_warn_125_in; // [R6]
    assign set_vec[`TRC_FLG_LOAD]  = run && load_result_ready_in;        // [R13]
    assign set_vec[`TRC_FLG_OVP]   = run && overvoltage_live_in;         // [R12]
    assign set_vec[`TRC_FLG_TWARN] = run && warn_hit;                    // [R11]
    assign set_vec[`TRC_FLG_TSD]   = run && thermal_shutdown_live_in;    // [R10]
    assign set_vec[`TRC_FLG_NOCLK] = run && ext_clk_invalid_in;          // [R9]
    // startup completion covers power-on, undervoltage and soft reset alike
    assign set_vec[`TRC_FLG_RST]   = (state_reg == TRC_ST_OTP) && (state_next == TRC_ST_RUN); // [R15]

    assign clr_vec[4:0] = (wr_ok && reg_addr_in == `TRC_ADDR_TOP) ? reg_wdata_in[4:0] : 5'h00; // [R14]
    assign clr_vec[`TRC_FLG_RST] = wr_ok && (reg_addr_in == `TRC_ADDR_RSTEV) && reg_wdata_in[0];

    // two phases per register, a nibble each
    for (genvar p = 0; p < 4; p++) begin : g_phase
        localparam int LSB  = `TRC_FLG_PH01_LSB + 3 * p;
        localparam int LANE = (p % 2) * 4;
        localparam logic [7:0] ADDR = (p < 2) ? `TRC_ADDR_PH01 : `TRC_ADDR_PH23;
        assign set_vec[LSB+2:LSB] = run ? {phase_pg_in[p], phase_sc_in[p], phase_ilim_in[p]} : 3'h0; // [R17]
        assign clr_vec[LSB+2:LSB] = (wr_ok && reg_addr_in == ADDR) ? reg_wdata_in[LANE+2:LANE] : 3'h0;
    end

    assign fl.set       = set_vec;
    assign fl.clr       = clr_vec;
    assign fl.clear_all = (state_reg == TRC_ST_HOLD);                    // [R16]

    // summary bits are pure views of the phase flags, so writes cannot touch them
    assign phase01_pending = |fl.flags[`TRC_FLG_PH23_LSB-1:`TRC_FLG_PH01_LSB];  // [R7] [R8]
    assign phase23_pending = |fl.flags[`TRC_NFLAGS-1:`TRC_FLG_PH23_LSB];       // [R7] [R8]

    always_comb begin
        rd_mux = 8'h00;
        unique case (reg_addr_in)
            `TRC_ADDR_SRST:  rd_mux = {srst_rsvd_reg, soft_reset_cmd_reg};
            `TRC_ADDR_CFG:   rd_mux = cfg_reg;
            `TRC_ADDR_TOP:   rd_mux = {top_rsvd_reg, phase23_pending, phase01_pending, fl.flags[4:0]};
            `TRC_ADDR_RSTEV: rd_mux = {rstev_rsvd_reg, fl.flags[`TRC_FLG_RST]};
            `TRC_ADDR_PH01:  rd_mux = {1'b0, fl.flags[11:9], 1'b0, fl.flags[8:6]};
            `TRC_ADDR_PH23:  rd_mux = {1'b0, fl.flags[17:15], 1'b0, fl.flags[14:12]};
            default:         rd_mux = 8'h00;
        endcase
    end

    // held between reads for a slow serial side
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_rd_in) begin
            reg_rdata_out <= rd_mux;
        end
    end

    // sequencer outputs, registered on the next state so they line up with state_reg
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            otp_load_out            <= 1'b0;
            serial_if_reset_out     <= 1'b1;
            regulator_enable_ok_out <= 1'b0;
        end else begin
            otp_load_out            <= (state_next == TRC_ST_OTP);                     // [R1]
            serial_if_reset_out     <= (state_next == TRC_ST_HOLD);                    // [R1]
            regulator_enable_ok_out <= (state_next == TRC_ST_RUN) && !fl.flags[`TRC_FLG_TSD]
                                       && !fl.set[`TRC_FLG_TSD];                       // [R10] [R16]
        end
    end

    // configuration outputs and the latched warning flag
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            delay_double_out               <= 1'b0;
            delay_step_ms_out              <= `TRC_DELAY_STEP_MS;
            ext_clk_pulldown_en_out        <= 1'b0;
            enable_in1_pulldown_en_out     <= 1'b0;
            enable_in2_pulldown_en_out     <= 1'b0;
            enable_in3_pulldown_en_out     <= 1'b0;
            thermal_warn_threshold_sel_out <= 1'b0;
            thermal_warn_flag_out          <= 1'b0;
        end else begin
            delay_double_out               <= cfg_reg[`TRC_CFG_DOUBLE_BIT];                // [R3]
            delay_step_ms_out              <= cfg_reg[`TRC_CFG_DOUBLE_BIT] ?
                                              `TRC_DELAY_STEP_DBL_MS : `TRC_DELAY_STEP_MS; // [R3]
            ext_clk_pulldown_en_out        <= cfg_reg[`TRC_CFG_CLKPD_BIT];                 // [R4]
            enable_in1_pulldown_en_out     <= cfg_reg[`TRC_CFG_EN1PD_BIT];                 // [R5]
            enable_in2_pulldown_en_out     <= cfg_reg[`TRC_CFG_EN2PD_BIT];                 // [R5]
            enable_in3_pulldown_en_out     <= cfg_reg[`TRC_CFG_EN3PD_BIT];                 // [R5]
            thermal_warn_threshold_sel_out <= cfg_reg[`TRC_CFG_WARNSEL_BIT];               // [R6]
            thermal_warn_flag_out          <= fl.flags[`TRC_FLG_TWARN];                    // [R11]
        end
    end

    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);

    property p_soft_reset;
        srst_wr |=> (state_reg == TRC_ST_HOLD) && serial_if_reset_out && !regulator_enable_ok_out;
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset did not take"); // [R1]

    property p_self_clear;
        srst_wr |=> ##1 !soft_reset_cmd_reg && fl.flags == '0;
    endproperty
    a_self_clear: assert property (p_self_clear) else $error("soft reset bit stuck"); // [R2]

    property p_delay_step;
        delay_step_ms_out == ($past(cfg_reg[`TRC_CFG_DOUBLE_BIT]) ? 2'h2 : 2'h1);
    endproperty
    a_delay_step: assert property (p_delay_step) else $error("delay step wrong"); // [R3]

    property p_pulldowns;
        {ext_clk_pulldown_en_out, enable_in3_pulldown_en_out, enable_in2_pulldown_en_out,
         enable_in1_pulldown_en_out} == {$past(cfg_reg[6]), $past(cfg_reg[4]), $past(cfg_reg[2]), $past(cfg_reg[1])};
    endproperty
    a_pulldowns: assert property (p_pulldowns) else $error("pulldown enable mismatch"); // [R4] [R5]

    property p_warn_sel;
        (run && cfg_reg[3] && thermal_warn_125_in && !thermal_warn_137_in && !fl.flags[2]) |=> !fl.flags[2];
    endproperty
    a_warn_sel: assert property (p_warn_sel) else $error("warning used wrong threshold"); // [R6]

    property p_summary;
        (reg_rd_in && reg_addr_in == `TRC_ADDR_TOP) |=>
            reg_rdata_out[6] == $past(|fl.flags[17:12]) && reg_rdata_out[5] == $past(|fl.flags[11:6]);
    endproperty
    a_summary: assert property (p_summary) else $error("summary bit mismatch"); // [R7] [R8]

    property p_noclk;
        (run && ext_clk_invalid_in) |=> fl.flags[`TRC_FLG_NOCLK];
    endproperty
    a_noclk: assert property (p_noclk) else $error("clock loss not latched"); // [R9]

    property p_tsd_block;
        (run && thermal_shutdown_live_in) |=> fl.flags[`TRC_FLG_TSD] && !regulator_enable_ok_out;
    endproperty
    a_tsd_block: assert property (p_tsd_block) else $error("shutdown left regulators on"); // [R10]

    property p_reset_flag;
        (state_reg == TRC_ST_OTP && state_next == TRC_ST_RUN) |=> fl.flags[`TRC_FLG_RST] && run;
    endproperty
    a_reset_flag: assert property (p_reset_flag) else $error("reset flag not latched"); // [R15]

    property p_off_outside_run;
        !run |-> !regulator_enable_ok_out;
    endproperty
    a_off_outside_run: assert property (p_off_outside_run) else $error("regulators on during reset"); // [R16]

    // levels reach their flags one edge later
    property p_warn_latch;
        (run && warn_hit) |=> fl.flags[`TRC_FLG_TWARN];
    endproperty
    a_warn_latch: assert property (p_warn_latch) else $error("warning lost"); // [R11]

    property p_ovp_latch;
        (run && overvoltage_live_in) |=> fl.flags[`TRC_FLG_OVP];
    endproperty
    a_ovp_latch: assert property (p_ovp_latch) else $error("overvoltage lost"); // [R12]

    property p_load_latch;
        (run && load_result_ready_in) |=> fl.flags[`TRC_FLG_LOAD];
    endproperty
    a_load_latch: assert property (p_load_latch) else $error("load done lost"); // [R13]
endmodule : trc_regs

// *** inc/trc_params.svh ***
// Purpose: offsets, field positions, reset values and timing counts of the top register bank
// Assumes: 8-bit register port, 25 MHz core clock
// Notes:   definitions only
`ifndef TRC_PARAMS_SVH
`define TRC_PARAMS_SVH

`define TRC_ADDR_SRST          8'h18
`define TRC_ADDR_CFG           8'h19
`define TRC_ADDR_TOP           8'h1A
`define TRC_ADDR_RSTEV         8'h1B
`define TRC_ADDR_PH01          8'h1C
`define TRC_ADDR_PH23          8'h1D

`define TRC_SRST_BIT           0
`define TRC_CFG_DOUBLE_BIT     7
`define TRC_CFG_CLKPD_BIT      6
`define TRC_CFG_EN3PD_BIT      4
`define TRC_CFG_WARNSEL_BIT    3
`define TRC_CFG_EN2PD_BIT      2
`define TRC_CFG_EN1PD_BIT      1
`define TRC_CFG_RSVD_MASK      8'h21
`define TRC_TOP_PH23_BIT       6
`define TRC_TOP_PH01_BIT       5

`define TRC_SRST_RESET         8'h00
`define TRC_CFG_RESET          8'h00
`define TRC_EVENT_RESET        8'h00

// flag bank layout: 0..4 top flags, 5 reset flag, 6..17 phase flags (ilim, sc, pg per phase)
`define TRC_NFLAGS             18
`define TRC_FLG_LOAD           0
`define TRC_FLG_OVP            1
`define TRC_FLG_TWARN          2
`define TRC_FLG_TSD            3
`define TRC_FLG_NOCLK          4
`define TRC_FLG_RST            5
`define TRC_FLG_PH01_LSB       6
`define TRC_FLG_PH23_LSB       12

`define TRC_CLK_PERIOD_NS      40
`define TRC_SRST_HOLD_NS       200
`define TRC_SRST_HOLD_CYC      ((`TRC_SRST_HOLD_NS + `TRC_CLK_PERIOD_NS - 1) / `TRC_CLK_PERIOD_NS)
`define TRC_DELAY_STEP_MS      2'h1
`define TRC_DELAY_STEP_DBL_MS  2'h2

`endif

// *** inc/trc_pkg.sv ***
// Purpose: shared types of the top register bank
// Assumes: nothing
// Notes:   constants live in trc_params.svh
package trc_pkg;
    typedef logic [7:0] trc_byte_type;
    typedef enum logic [1:0] {
        TRC_ST_HOLD = 2'b00,
        TRC_ST_OTP  = 2'b01,
        TRC_ST_RUN  = 2'b10
    } trc_seq_state_type;
endpackage : trc_pkg

// *** inc/trc_flag_if.sv ***
// Purpose: carries set, clear and state of the sticky event flags
// Assumes: one bank per register block
// Notes:   widths fixed by the flag layout
`timescale 1ns/100ps
`include "trc_params.svh"
interface trc_flag_if;
    logic [`TRC_NFLAGS-1:0] set;
    logic [`TRC_NFLAGS-1:0] clr;
    logic                   clear_all;
    logic [`TRC_NFLAGS-1:0] flags;
    modport bank (input set, input clr, input clear_all, output flags);
    modport ctrl (output set, output clr, output clear_all, input flags);
endinterface : trc_flag_if

// *** core/trc_flag_bank.sv ***
// Purpose: bank of write-one-to-clear sticky flags
// Assumes: set and clr are qualified by the owner; set may be held high as a level
// Notes:   set beats clear so no event is lost
`timescale 1ns/100ps
`include "trc_params.svh"
module trc_flag_bank (
    input  wire logic core_clk_in,
    input  wire logic rst_in,
    trc_flag_if.bank  fl
);
    import trc_pkg::*;

    wire [`TRC_NFLAGS-1:0] flag_vec;

    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);

    for (genvar i = 0; i < `TRC_NFLAGS; i++) begin : g_flag
        logic flag_bit_reg;
        always_ff @(posedge core_clk_in or posedge rst_in) begin
            if (rst_in) begin
                flag_bit_reg <= 1'b0;
            end else if (fl.clear_all) begin
                flag_bit_reg <= 1'b0;
            end else if (fl.set[i]) begin
                flag_bit_reg <= 1'b1;                        // [R19]
            end else if (fl.clr[i]) begin
                flag_bit_reg <= 1'b0;                        // [R14]
            end
        end
        assign flag_vec[i] = flag_bit_reg;

        property p_set_wins;
            (fl.set[i] && fl.clr[i] && !fl.clear_all) |=> flag_bit_reg;
        endproperty
        a_set_wins: assert property (p_set_wins) else $error("flag lost on clear"); // [R19]
        property p_hold;
            (flag_bit_reg && !fl.clr[i] && !fl.clear_all) |=> flag_bit_reg;
        endproperty
        a_hold: assert property (p_hold) else $error("flag dropped without clear"); // [R18]
        property p_w1c;
            (flag_bit_reg && fl.clr[i] && !fl.set[i]) |=> !flag_bit_reg;
        endproperty
        a_w1c: assert property (p_w1c) else $error("flag not cleared by one"); // [R14]
    end

    assign fl.flags = flag_vec;
endmodule : trc_flag_bank

// *** test/trc_host_model.sv ***
// Purpose: host side of the register port, one access per strobe
// Assumes: strobes sampled on the rising edge, read data one cycle later
// Notes:   idle write data is inverted so a stale byte never looks valid
`timescale 1ns/100ps
module trc_host_model (
    input  wire trc_pkg::trc_byte_type rdata_in,
    input  wire logic                  core_clk_in,
    output      logic [7:0]            addr_out,
    output      logic                  wr_out,
    output      logic                  rd_out,
    output      trc_pkg::trc_byte_type wdata_out
);
    import trc_pkg::*;
    initial begin
        addr_out  = 8'h00;
        wr_out    = 1'b0;
        rd_out    = 1'b0;
        wdata_out = 8'h00;
    end
    // flags are acknowledged only by ones in the written byte
    task automatic wr(input logic [7:0] a, input trc_byte_type d);
        @(posedge core_clk_in);
        addr_out  <= a;
        wdata_out <= d;
        wr_out    <= 1'b1;
        @(posedge core_clk_in);
        wr_out    <= 1'b0;
        wdata_out <= ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output trc_byte_type d);
        @(posedge core_clk_in);
        addr_out <= a;
        rd_out   <= 1'b1;
        @(posedge core_clk_in);
        rd_out <= 1'b0;
        #1;
        d = rdata_in;
    endtask : rd
endmodule : trc_host_model

// *** test/top_reset_config_irq_regs_tb.sv ***
// Purpose: self-checking bench of the top register bank
// Assumes: programmed default word all ones, load completes at once
// Notes:   config rows first, then events, clears and the three reset causes
`timescale 1ns/100ps
`include "trc_params.svh"
module top_reset_config_irq_regs_tb;
    import trc_pkg::*;
    logic core_clk_in, rst_in, reg_wr_in, reg_rd_in, power_on_reset_n_in, analog_supply_uv_in, otp_done_in;
    logic ext_clk_invalid_in, thermal_shutdown_live_in, thermal_warn_125_in, thermal_warn_137_in;
    logic overvoltage_live_in, load_result_ready_in, otp_load_out, serial_if_reset_out, regulator_enable_ok_out;
    logic delay_double_out, ext_clk_pulldown_en_out, enable_in1_pulldown_en_out, enable_in2_pulldown_en_out;
    logic enable_in3_pulldown_en_out, thermal_warn_threshold_sel_out, thermal_warn_flag_out;
    logic [1:0]   delay_step_ms_out;
    logic [3:0]   phase_pg_in, phase_sc_in, phase_ilim_in;
    logic [7:0]   reg_addr_in;
    trc_byte_type reg_wdata_in, reg_rdata_out, otp_config_in;
    int           fail_count = 0;
    int           n_compared = 0;
    logic [23:0]  rows [4] = '{24'h00_00_20, 24'hFF_FF_DF, 24'h96_96_CB, 24'h48_48_34};
    wire  [7:0]   cfg_outs = {delay_double_out, delay_step_ms_out, ext_clk_pulldown_en_out,
                              enable_in3_pulldown_en_out, thermal_warn_threshold_sel_out,
                              enable_in2_pulldown_en_out, enable_in1_pulldown_en_out};

    trc_regs dut_u (.core_clk_in, .rst_in, .reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_wdata_in, .reg_rdata_out,
        .power_on_reset_n_in, .analog_supply_uv_in, .otp_config_in, .otp_done_in, .ext_clk_invalid_in,
        .thermal_shutdown_live_in, .thermal_warn_125_in, .thermal_warn_137_in, .overvoltage_live_in,
        .load_result_ready_in, .phase_pg_in, .phase_sc_in, .phase_ilim_in, .otp_load_out, .serial_if_reset_out,
        .regulator_enable_ok_out, .delay_double_out, .delay_step_ms_out, .ext_clk_pulldown_en_out,
        .enable_in1_pulldown_en_out, .enable_in2_pulldown_en_out, .enable_in3_pulldown_en_out,
        .thermal_warn_threshold_sel_out, .thermal_warn_flag_out);
    trc_host_model host_u (.rdata_in(reg_rdata_out), .core_clk_in, .addr_out(reg_addr_in), .wr_out(reg_wr_in),
        .rd_out(reg_rd_in), .wdata_out(reg_wdata_in));

    always #20 core_clk_in = ~core_clk_in;

    task automatic conclude();
        if (fail_count == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : conclude
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        trc_byte_type d;
        host_u.rd(a, d);
        check(d, exp);
    endtask : rdchk
    // bounded wait: a stuck start-up shows as a failed compare, not a hang
    task automatic startup();
        int n;
        n = 0;
        while ((serial_if_reset_out !== 1'b0 || otp_load_out !== 1'b0) && n < 60) begin
            @(posedge core_clk_in);
            #1;
            n++;
        end
        check({6'h00, serial_if_reset_out, otp_load_out}, 8'h00);
    endtask : startup
    task automatic settle();
        repeat (2) @(posedge core_clk_in);
        #1;
    endtask : settle

    initial begin
        #(40 * 5000);
        fail_count++;
        conclude();
    end

    initial begin
        {core_clk_in, analog_supply_uv_in, ext_clk_invalid_in} = 3'h0;
        {thermal_shutdown_live_in, thermal_warn_125_in, thermal_warn_137_in} = 3'h0;
        {overvoltage_live_in, load_result_ready_in, phase_pg_in, phase_sc_in, phase_ilim_in} = 14'h0000;
        {rst_in, power_on_reset_n_in, otp_done_in} = 3'h7;
        otp_config_in = 8'hFF;
        repeat (6) @(posedge core_clk_in);
        rst_in <= 1'b0;
        startup();
        rdchk(`TRC_ADDR_CFG, 8'hDE);
        rdchk(`TRC_ADDR_RSTEV, 8'h01);
        for (int i = 0; i < 4; i++) begin
            host_u.wr(`TRC_ADDR_CFG, rows[i][23:16]);
            settle();
            check(cfg_outs, rows[i][7:0]);
            rdchk(`TRC_ADDR_CFG, rows[i][15:8]);
        end
        // warning threshold now 137, so the 125 crossing must not latch
        @(posedge core_clk_in);
        {thermal_warn_125_in, load_result_ready_in, overvoltage_live_in, ext_clk_invalid_in} <= 4'hF;
        @(posedge core_clk_in);
        {load_result_ready_in, overvoltage_live_in} <= 2'h0;
        settle();
        check({7'h00, thermal_warn_flag_out}, 8'h00);
        rdchk(`TRC_ADDR_TOP, 8'h13);
        @(posedge core_clk_in);
        {thermal_warn_137_in, thermal_shutdown_live_in} <= 2'h3;
        @(posedge core_clk_in);
        {thermal_warn_137_in, thermal_shutdown_live_in, thermal_warn_125_in} <= 3'h0;
        settle();
        check({6'h00, regulator_enable_ok_out, thermal_warn_flag_out}, 8'h01);
        rdchk(`TRC_ADDR_TOP, 8'h1F);
        host_u.wr(`TRC_ADDR_TOP, 8'h00);
        rdchk(`TRC_ADDR_TOP, 8'h1F);
        host_u.wr(`TRC_ADDR_TOP, 8'h1F);
        rdchk(`TRC_ADDR_TOP, 8'h10);
        @(posedge core_clk_in);
        ext_clk_invalid_in <= 1'b0;
        host_u.wr(`TRC_ADDR_TOP, 8'h10);
        rdchk(`TRC_ADDR_TOP, 8'h00);
        check({7'h00, regulator_enable_ok_out}, 8'h01);
        @(posedge core_clk_in);
        {phase_pg_in, phase_sc_in, phase_ilim_in} <= 12'h428;
        @(posedge core_clk_in);
        {phase_pg_in, phase_sc_in, phase_ilim_in} <= 12'h000;
        rdchk(`TRC_ADDR_TOP, 8'h60);
        rdchk(`TRC_ADDR_PH23, 8'h14);
        rdchk(`TRC_ADDR_PH01, 8'h20);
        host_u.wr(`TRC_ADDR_TOP, 8'h60);
        rdchk(`TRC_ADDR_TOP, 8'h60);
        host_u.wr(`TRC_ADDR_PH23, 8'h04);
        rdchk(`TRC_ADDR_TOP, 8'h60);
        host_u.wr(`TRC_ADDR_PH23, 8'h10);
        rdchk(`TRC_ADDR_TOP, 8'h20);
        rdchk(8'h20, 8'h00);
        // undervoltage, power-on pin, then soft reset
        for (int i = 0; i < 3; i++) begin
            host_u.wr(`TRC_ADDR_RSTEV, 8'h01);
            rdchk(`TRC_ADDR_RSTEV, 8'h00);
            if (i == 2) begin
                host_u.wr(`TRC_ADDR_SRST, 8'h01);
            end else begin
                @(posedge core_clk_in);
                if (i == 0) analog_supply_uv_in <= 1'b1;
                else power_on_reset_n_in <= 1'b0;
                @(posedge core_clk_in);
                {analog_supply_uv_in, power_on_reset_n_in} <= 2'h1;
            end
            @(posedge core_clk_in);
            #1;
            check({6'h00, serial_if_reset_out, regulator_enable_ok_out}, 8'h02);
            startup();
            rdchk(`TRC_ADDR_SRST, 8'h00);
            rdchk(`TRC_ADDR_RSTEV, 8'h01);
            rdchk(`TRC_ADDR_PH01, 8'h00);
            rdchk(`TRC_ADDR_CFG, 8'hDE);
        end
        host_u.wr(`TRC_ADDR_CFG, 8'h00);
        @(posedge core_clk_in);
        thermal_warn_125_in <= 1'b1;
        settle();
        check({7'h00, thermal_warn_flag_out}, 8'h01);
        conclude();
    end
endmodule : top_reset_config_irq_regs_tb
